// [design/bcd_add_unit.v]
// Execution slice for multiply-adjust, subtract-adjust, add and add-with-carry,
// with operand-form decode, status flags and memory operand fault checks.
// Assumes one clock, a 32-bit AXI4-Lite master, and segment, paging and
// alignment check results supplied by software through the environment word.
`timescale 1ns/1ps
`include "bcd_add_consts.vh"
`default_nettype none

module bcd_add_unit (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_n_i,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function [31:0] apply_strb;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        apply_strb[k*8 +: 8] = strb[k] ? new_v[k*8 +: 8] : old_v[k*8 +: 8];
      end
    end
  endfunction

  function [31:0] size_mask;
    input [1:0] sz;
    begin
      case (sz)
        2'h0: size_mask = 32'h000000FF;
        2'h1: size_mask = 32'h0000FFFF;
        default: size_mask = 32'hFFFFFFFF;
      endcase
    end
  endfunction

  function top_bit;
    input [32:0] v;
    input [1:0] sz;
    begin
      case (sz)
        2'h0: top_bit = v[7];
        2'h1: top_bit = v[15];
        default: top_bit = v[31];
      endcase
    end
  endfunction

  function carry_bit;
    input [32:0] v;
    input [1:0] sz;
    begin
      case (sz)
        2'h0: carry_bit = v[8];
        2'h1: carry_bit = v[16];
        default: carry_bit = v[32];
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg [31:0] ctrl_reg;
  reg [31:0] dest_reg;
  reg [31:0] src_reg;
  reg [31:0] imm_reg;
  reg [31:0] acc_reg;
  reg [31:0] flags_reg;
  reg [31:0] env_reg;
  reg [31:0] xlat_code_reg;
  reg [31:0] result_reg;
  reg [31:0] status_reg;
  reg [31:0] fault_code_reg;
  reg go_reg;

  reg [7:0] awaddr_reg;
  reg aw_held_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg w_held_reg;

  wire wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid_o;
  wire go_wr = wr_fire && (awaddr_reg == `REG_CTRL) && wstrb_reg[3] && wdata_reg[`CTRL_GO_BIT];

  assign s_axi_awready_o = !aw_held_reg;
  assign s_axi_wready_o = !w_held_reg;
  assign s_axi_arready_o = !s_axi_rvalid_o;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and execute

  reg [7:0] opcode;
  reg [7:0] second_byte;
  reg [1:0] full_sz;
  reg [1:0] sz;
  reg is_add;
  reg is_adc;
  reg is_mult_adj;
  reg is_sub_adj;
  reg illegal;
  reg acc_dest;
  reg imm_src;
  reg dest_mem_form;
  reg [31:0] mask;
  reg [31:0] op_a;
  reg [31:0] op_b;
  reg [32:0] full_sum;
  reg [31:0] sum;
  reg [7:0] acc_low;
  reg [7:0] acc_high;
  reg [7:0] quot;
  reg [7:0] rem;
  reg adjust;
  reg [7:0] low_fix;
  reg [1:0] mode;
  reg mem_chk;
  reg [2:0] fault_kind;
  reg err_valid;
  reg [31:0] flags_new;
  reg [31:0] acc_new;

  always @* begin
    opcode = ctrl_reg[7:0];
    second_byte = ctrl_reg[15:8];
    full_sz = (ctrl_reg[17:16] == `CTRL_SIZE_WORD) ? 2'h1 : 2'h2;
    sz = 2'h0;
    is_add = 1'b0;
    is_adc = 1'b0;
    is_mult_adj = 1'b0;
    is_sub_adj = 1'b0;
    illegal = 1'b0;
    acc_dest = 1'b0;
    imm_src = 1'b0;
    dest_mem_form = 1'b0;
    op_b = src_reg;
    case (opcode)
      8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h11, 8'h12, 8'h13: begin
        is_add = !opcode[4];
        is_adc = opcode[4];
        sz = opcode[0] ? full_sz : 2'h0;
        dest_mem_form = !opcode[1];
      end
      8'h04, 8'h05, 8'h14, 8'h15: begin
        is_add = !opcode[4];
        is_adc = opcode[4];
        sz = opcode[0] ? full_sz : 2'h0;
        acc_dest = 1'b1;
        imm_src = 1'b1;
      end
      `OP_GRP_BYTE, `OP_GRP_FULL, `OP_GRP_SEXT: begin
        is_add = (second_byte[5:3] == `GRP_ADD);
        is_adc = (second_byte[5:3] == `GRP_ADC);
        illegal = !is_add && !is_adc;
        sz = (opcode == `OP_GRP_BYTE) ? 2'h0 : full_sz;
        imm_src = 1'b1;
        dest_mem_form = 1'b1;
      end
      `OP_MULT_ADJUST: is_mult_adj = 1'b1;
      `OP_SUB_ADJUST: is_sub_adj = 1'b1;
      default: illegal = 1'b1;
    endcase
    mask = size_mask(sz);
    if (imm_src) begin
      // Byte immediates widen by sign; full immediates already match width
      if (sz == 2'h0 || opcode == `OP_GRP_SEXT) begin
        op_b = {{24{imm_reg[7]}}, imm_reg[7:0]} & mask;
      end else begin
        op_b = imm_reg & mask;
      end
    end else begin
      op_b = src_reg & mask;
    end
    op_a = (acc_dest ? acc_reg : dest_reg) & mask;
    full_sum = {1'b0, op_a} + {1'b0, op_b} + {32'h0, is_adc & flags_reg[`FLG_CARRY]};
    sum = full_sum[31:0] & mask;

    // Decimal adjust datapath
    acc_low = acc_reg[7:0];
    acc_high = acc_reg[15:8];
    quot = 8'h00;
    rem = 8'h00;
    if (second_byte != 8'h00) begin
      quot = acc_low / second_byte;
      rem = acc_low % second_byte;
    end
    adjust = (acc_low[3:0] > `BCD_LIMIT) || flags_reg[`FLG_AUX];
    low_fix = adjust ? (acc_low - `BCD_FIX) : acc_low;

    // Memory operand fault checks, first match wins
    mode = env_reg[`ENV_MODE_LSB +: 2];
    mem_chk = (is_add || is_adc) && env_reg[`ENV_MEM_OP];
    fault_kind = `FK_NONE;
    err_valid = 1'b0;
    if (mem_chk && mode == `MODE_PROT && dest_mem_form && env_reg[`ENV_DEST_RO]) begin
      fault_kind = `FK_PROT;
      err_valid = 1'b1;
    end else if (mem_chk && env_reg[`ENV_SEG_LIM]) begin
      fault_kind = `FK_PROT;
      err_valid = (mode != `MODE_REAL);
    end else if (mem_chk && mode == `MODE_PROT && env_reg[`ENV_NULL_SEL]) begin
      fault_kind = `FK_PROT;
      err_valid = 1'b1;
    end else if (mem_chk && env_reg[`ENV_STK_LIM]) begin
      fault_kind = `FK_SS;
      err_valid = (mode != `MODE_REAL);
    end else if (mem_chk && mode != `MODE_REAL && env_reg[`ENV_XLAT_FAIL]) begin
      fault_kind = `FK_XLAT;
      err_valid = 1'b1;
    end else if (mem_chk && env_reg[`ENV_ALIGN_EN] && env_reg[`ENV_UNALIGNED] &&
                 ((mode == `MODE_PROT && env_reg[`ENV_CPL_LSB +: 2] == `CPL_USER) || mode == `MODE_V86)) begin
      fault_kind = `FK_ALIGN;
      err_valid = 1'b1;
    end else if (is_mult_adj && second_byte == 8'h00) begin
      fault_kind = `FK_DIVZ;
    end

    // Next accumulator and flags, used only when no fault
    flags_new = flags_reg;
    acc_new = acc_reg;
    if (is_add || is_adc) begin
      flags_new[`FLG_CARRY] = carry_bit(full_sum, sz);
      flags_new[`FLG_OVFL] = (top_bit({1'b0, op_a}, sz) == top_bit({1'b0, op_b}, sz)) &&
                             (top_bit({1'b0, sum}, sz) != top_bit({1'b0, op_a}, sz));
      flags_new[`FLG_SIGN] = top_bit({1'b0, sum}, sz);
      flags_new[`FLG_ZERO] = (sum == 32'h00000000);
      flags_new[`FLG_AUX] = op_a[4] ^ op_b[4] ^ sum[4];
      flags_new[`FLG_PARITY] = ~^sum[7:0];
      if (acc_dest) begin
        acc_new = (acc_reg & ~mask) | sum;
      end
    end else if (is_mult_adj) begin
      acc_new = {acc_reg[31:16], quot, rem};
      flags_new[`FLG_SIGN] = rem[7];
      flags_new[`FLG_ZERO] = (rem == 8'h00);
      flags_new[`FLG_PARITY] = ~^rem;
    end else if (is_sub_adj) begin
      acc_new = {acc_reg[31:16], adjust ? (acc_high - 8'h01) : acc_high, 4'h0, low_fix[3:0]};
      flags_new[`FLG_AUX] = adjust;
      flags_new[`FLG_CARRY] = adjust;
    end
  end

  wire commit = go_reg && !illegal && (fault_kind == `FK_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // Write channel and register updates

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      awaddr_reg <= 8'h00;
      aw_held_reg <= 1'b0;
      wdata_reg <= `RST_WORD;
      wstrb_reg <= 4'h0;
      w_held_reg <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `RESP_OKAY;
      ctrl_reg <= `RST_WORD;
      dest_reg <= `RST_WORD;
      src_reg <= `RST_WORD;
      imm_reg <= `RST_WORD;
      acc_reg <= `RST_WORD;
      flags_reg <= `RST_FLAGS;
      env_reg <= `RST_WORD;
      xlat_code_reg <= `RST_WORD;
      result_reg <= `RST_WORD;
      status_reg <= `RST_WORD;
      fault_code_reg <= `RST_WORD;
      go_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && !aw_held_reg) begin
        awaddr_reg <= s_axi_awaddr_i;
        aw_held_reg <= 1'b1;
      end
      if (s_axi_wvalid_i && !w_held_reg) begin
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
        w_held_reg <= 1'b1;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
      go_reg <= go_wr;
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= `RESP_OKAY;
        case (awaddr_reg)
          `REG_CTRL: ctrl_reg <= apply_strb(ctrl_reg, wdata_reg, wstrb_reg) & 32'h0003FFFF;
          `REG_DEST: dest_reg <= apply_strb(dest_reg, wdata_reg, wstrb_reg);
          `REG_SRC: src_reg <= apply_strb(src_reg, wdata_reg, wstrb_reg);
          `REG_IMM: imm_reg <= apply_strb(imm_reg, wdata_reg, wstrb_reg);
          `REG_ACC: acc_reg <= apply_strb(acc_reg, wdata_reg, wstrb_reg);
          `REG_FLAGS: flags_reg <= (apply_strb(flags_reg, wdata_reg, wstrb_reg) & `FLG_MASK) | `RST_FLAGS;
          `REG_ENV: env_reg <= apply_strb(env_reg, wdata_reg, wstrb_reg) & 32'h00000FFF;
          `REG_XLAT_CODE: xlat_code_reg <= apply_strb(xlat_code_reg, wdata_reg, wstrb_reg);
          `REG_RESULT, `REG_STATUS, `REG_FAULT_CODE: s_axi_bresp_o <= `RESP_OKAY;
          default: s_axi_bresp_o <= `RESP_SLVERR;
        endcase
        // A new start clears the previous outcome
        if (go_wr) begin
          status_reg <= `RST_WORD;
        end
      end
      // Execution lands after any same-cycle software write
      if (go_reg) begin
        status_reg[`STS_DONE] <= 1'b1;
        status_reg[`STS_ILLEGAL] <= illegal;
        status_reg[`STS_FAULT] <= !illegal && (fault_kind != `FK_NONE);
        status_reg[`STS_KIND_LSB +: 3] <= illegal ? `FK_NONE : fault_kind;
        status_reg[`STS_ERR_VALID] <= !illegal && err_valid;
        status_reg[`STS_DEST_WR] <= commit && (is_add || is_adc) && !acc_dest;
        status_reg[`STS_ACC_DEST] <= commit && (acc_dest || is_mult_adj || is_sub_adj);
        fault_code_reg <= (fault_kind == `FK_XLAT) ? xlat_code_reg : `RST_WORD;
        if (commit) begin
          acc_reg <= acc_new;
          flags_reg <= flags_new;
          if ((is_add || is_adc) && !acc_dest) begin
            result_reg <= sum;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  reg [31:0] rd_word;
  reg rd_hit;

  always @* begin
    rd_hit = 1'b1;
    rd_word = `RST_WORD;
    case (s_axi_araddr_i)
      `REG_CTRL: rd_word = ctrl_reg;
      `REG_DEST: rd_word = dest_reg;
      `REG_SRC: rd_word = src_reg;
      `REG_IMM: rd_word = imm_reg;
      `REG_ACC: rd_word = acc_reg;
      `REG_FLAGS: rd_word = flags_reg;
      `REG_ENV: rd_word = env_reg;
      `REG_XLAT_CODE: rd_word = xlat_code_reg;
      `REG_RESULT: rd_word = result_reg;
      `REG_STATUS: rd_word = status_reg;
      `REG_FAULT_CODE: rd_word = fault_code_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= `RST_WORD;
      s_axi_rresp_o <= `RESP_OKAY;
    end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_word;
      s_axi_rresp_o <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

endmodule // bcd_add_unit

`default_nettype wire

// [design/bcd_add_consts.vh]
// Constants of the decimal-adjust and add execution slice: register map,
// field positions, reset values, opcodes and fault kinds.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
//
// Summary of operation
// - Multiply-adjust: acc_high gets quotient, acc_low remainder.
// - Divisor is the instruction's second byte; zero raises divide fault.
// - Multiply-adjust sets sign, zero, parity from result.
// - Subtract-adjust adjusts when nibble above nine or aux.
// - Else clear carry/aux; always zero acc_low top nibble.
// - Subtract-adjust defines only carry and aux carry.
// - Add-with-carry sums destination, source and carry.
// - Plain add stores destination plus source in destination.
// - Immediate sign-extended to destination width first.
// - Overflow signed, carry unsigned, sign is top bit.
// - Add forms update all six arithmetic flags.
// - Add-with-carry opcodes 10-15, 80/81/83 reg two.
// - Plain add opcodes 00-05, 80/81/83 reg zero.
// - Protected mode: nonwritable destination raises protection fault.
// - Segment limit exceeded raises protection fault, code unless real.
// - Protected mode: null data selector raises protection fault.
// - Stack limit exceeded raises stack fault, code outside real.
// - Translation failure faults with code, not in real mode.
// - Unaligned with checking: fault at level three or v86.
`ifndef BCD_ADD_CONSTS_VH
`define BCD_ADD_CONSTS_VH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_DEST 8'h04
`define REG_SRC 8'h08
`define REG_IMM 8'h0C
`define REG_ACC 8'h10
`define REG_FLAGS 8'h14
`define REG_ENV 8'h18
`define REG_XLAT_CODE 8'h1C
`define REG_RESULT 8'h20
`define REG_STATUS 8'h24
`define REG_FAULT_CODE 8'h28

// Control fields
`define CTRL_GO_BIT 31
`define CTRL_SIZE_WORD 2'h1

// Flag bit positions in the flags register
`define FLG_CARRY 0
`define FLG_PARITY 2
`define FLG_AUX 4
`define FLG_ZERO 6
`define FLG_SIGN 7
`define FLG_OVFL 11
`define FLG_MASK 32'h000008D5

// Environment fields
`define ENV_MODE_LSB 0
`define ENV_CPL_LSB 2
`define ENV_ALIGN_EN 4
`define ENV_MEM_OP 5
`define ENV_DEST_RO 6
`define ENV_NULL_SEL 7
`define ENV_SEG_LIM 8
`define ENV_STK_LIM 9
`define ENV_XLAT_FAIL 10
`define ENV_UNALIGNED 11

// Operating modes and privilege
`define MODE_REAL 2'h0
`define MODE_PROT 2'h1
`define MODE_V86 2'h2
`define CPL_USER 2'h3

// Status fields
`define STS_DONE 0
`define STS_DEST_WR 1
`define STS_FAULT 2
`define STS_KIND_LSB 4
`define STS_ERR_VALID 8
`define STS_ILLEGAL 9
`define STS_ACC_DEST 10

// Fault kinds
`define FK_NONE 3'h0
`define FK_PROT 3'h1
`define FK_SS 3'h2
`define FK_XLAT 3'h3
`define FK_ALIGN 3'h4
`define FK_DIVZ 3'h5

// Reset values
`define RST_WORD 32'h00000000
`define RST_FLAGS 32'h00000002

// Opcodes
`define OP_MULT_ADJUST 8'hD4
`define OP_SUB_ADJUST 8'h3F
`define OP_GRP_BYTE 8'h80
`define OP_GRP_FULL 8'h81
`define OP_GRP_SEXT 8'h83
`define GRP_ADD 3'h0
`define GRP_ADC 3'h2
`define BCD_LIMIT 4'h9
`define BCD_FIX 8'h06

// AXI response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [testbench/axi_lite_master_model.sv]
// AXI4-Lite master model standing in for the decoder and operand access unit.
// Assumes one clock shared with the slave; the bench calls its tasks.
`timescale 1ns/1ps
`default_nettype none
module axi_lite_master_model (
  // Clock
  input wire logic clk_sys_i,
  // Write side
  output logic [7:0] awaddr_o, output logic awvalid_o, input wire logic awready_i,
  output logic [31:0] wdata_o, output logic [3:0] wstrb_o, output logic wvalid_o, input wire logic wready_i,
  input wire logic [1:0] bresp_i, input wire logic bvalid_i, output logic bready_o,
  // Read side
  output logic [7:0] araddr_o, output logic arvalid_o, input wire logic arready_i,
  input wire logic [31:0] rdata_i, input wire logic [1:0] rresp_i, input wire logic rvalid_i, output logic rready_o
);
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end
  // Released payload is inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge clk_sys_i);
    awaddr_o <= a;
    awvalid_o <= 1'b1;
    wdata_o <= d;
    wstrb_o <= 4'hF;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (awvalid_o && awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
      end
      if (wvalid_o && wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o <= ~d;
      end
    end while (bvalid_i !== 1'b1);
    resp = bresp_i;
    bready_o <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk_sys_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (arvalid_o && arready_i) begin
        arvalid_o <= 1'b0;
        araddr_o <= ~a;
      end
    end while (rvalid_i !== 1'b1);
    d = rdata_i;
    resp = rresp_i;
    rready_o <= 1'b0;
  endtask
endmodule // axi_lite_master_model
`default_nettype wire

// [testbench/bcd_add_unit_chk.sv]
// Bus-level checker for the execution slice, bound to its top module.
// Assumes the register map and status layout of the constants header.
`timescale 1ns/1ps
`include "bcd_add_consts.vh"
`default_nettype none
module bcd_add_unit_chk (
  // Clock and reset
  input wire logic clk_sys_i, input wire logic rst_n_i,
  // Write side
  input wire logic s_axi_awvalid_i, input wire logic s_axi_awready_o, input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o, input wire logic [1:0] s_axi_bresp_o, input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // Read side
  input wire logic [7:0] s_axi_araddr_i, input wire logic s_axi_arvalid_i, input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o, input wire logic [1:0] s_axi_rresp_o, input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  wire ar_take = s_axi_arvalid_i && s_axi_arready_o;
  bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped early");
  read_answer_a: assert property (ar_take |=> s_axi_rvalid_o) else $error("read not answered");
  ar_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o) else $error("address taken during read data");
  write_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    && !s_axi_bvalid_o |-> ##2 s_axi_bvalid_o) else $error("write not answered");
  bvalid_cause_a: assert property ($rose(s_axi_bvalid_o) |-> $past(!s_axi_awready_o && !s_axi_wready_o))
    else $error("response without write");
  rvalid_cause_a: assert property ($rose(s_axi_rvalid_o) |-> $past(ar_take)) else $error("read data without address");
  unmapped_err_a: assert property (ar_take && s_axi_araddr_i > `REG_FAULT_CODE |=>
    s_axi_rresp_o == `RESP_SLVERR && s_axi_rdata_o == 32'h0) else $error("unmapped read not refused");
  flags_shape_a: assert property (ar_take && s_axi_araddr_i == `REG_FLAGS |=>
    s_axi_rdata_o[1] && (s_axi_rdata_o & ~32'h000008D7) == 32'h0) else $error("flags word malformed");
  fault_quiet_a: assert property (ar_take && s_axi_araddr_i == `REG_STATUS |=>
    !(s_axi_rdata_o[`STS_FAULT] && (s_axi_rdata_o[`STS_DEST_WR] || s_axi_rdata_o[`STS_ACC_DEST])))
    else $error("fault with state update");
endmodule // bcd_add_unit_chk
bind bcd_add_unit bcd_add_unit_chk u_bcd_add_unit_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i));
`default_nettype wire

// [testbench/bcd_add_unit_tb_top.sv]
// Self-checking bench for the execution slice, driven over AXI4-Lite.
// Assumes the register map of the constants header and the master model.
`timescale 1ns/1ps
`include "bcd_add_consts.vh"
`default_nettype none
module bcd_add_unit_tb_top;
  logic clk_sys_i;
  logic rst_n_i;
  wire [7:0] awaddr, araddr;
  wire [31:0] wdata, rdata;
  wire [3:0] wstrb;
  wire [1:0] bresp, rresp;
  wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int failures = 0;
  int samples_checked = 0;
  logic [31:0] acc_r, flg_r, res_r, sts_r, rd_d;
  logic [1:0] rsp;
  bcd_add_unit u_bcd_add_unit (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
  axi_lite_master_model u_axi_lite_master_model (.clk_sys_i(clk_sys_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
    .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
    .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid),
    .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_axi_lite_master_model.wr(a, d, rsp);
  endtask
  task automatic rd(input logic [7:0] a);
    u_axi_lite_master_model.rd(a, rd_d, rsp);
  endtask
  // Loads operands, starts one instruction, waits for done, reads results
  task automatic run(input logic [7:0] op, b2, input logic [1:0] sz, input logic [31:0] dst, src, imm, acc, flg, env);
    int n;
    wr(`REG_DEST, dst);
    wr(`REG_SRC, src);
    wr(`REG_IMM, imm);
    wr(`REG_ACC, acc);
    wr(`REG_FLAGS, flg);
    wr(`REG_ENV, env);
    wr(`REG_CTRL, {1'b1, 13'h0, sz, b2, op});
    n = 0;
    do begin
      rd(`REG_STATUS);
      n++;
    end while (rd_d[`STS_DONE] !== 1'b1 && n < 20);
    sts_r = rd_d;
    chk(sts_r[`STS_DONE], 1, "done");
    rd(`REG_ACC);
    acc_r = rd_d;
    rd(`REG_FLAGS);
    flg_r = rd_d;
    rd(`REG_RESULT);
    res_r = rd_d;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(`REG_FLAGS);
    chk(rd_d, `RST_FLAGS, "flags reset");
    rd(`REG_ACC);
    chk(rd_d, `RST_WORD, "acc reset");
    rd(8'h3C);
    chk(rsp, `RESP_SLVERR, "unmapped read");
    wr(8'h3C, 32'h5A5A5A5A);
    chk(rsp, `RESP_SLVERR, "unmapped write");
  endtask
  // Entry: acc_low, divisor, quotient, remainder
  task automatic t_mult();
    logic [31:0] t [4] = '{32'h4F0A0709, 32'h4F070B02, 32'h140A0200, 32'h85900085};
    logic [31:0] f;
    foreach (t[i]) begin
      run(`OP_MULT_ADJUST, t[i][23:16], 2'h0, 0, 0, 0, {16'h1234, 8'h00, t[i][31:24]}, `RST_FLAGS, 0);
      f = `RST_FLAGS;
      f[`FLG_SIGN] = t[i][7];
      f[`FLG_ZERO] = t[i][7:0] == 8'h00;
      f[`FLG_PARITY] = ~^t[i][7:0];
      chk(acc_r[15:0], t[i][15:0], "mult adjust acc");
      chk(flg_r, f, "mult adjust flags");
    end
  endtask
  // Entry: acc in, acc out, flags in, carry and aux carry out
  task automatic t_sub();
    logic [47:0] t [4] = '{48'h000BFF050011, 48'h0503040D1011, 48'h05C705070100, 48'h0A090A090000};
    foreach (t[i]) begin
      run(`OP_SUB_ADJUST, 0, 2'h0, 0, 0, 0, {16'h5A5A, t[i][47:32]}, `RST_FLAGS | t[i][15:8], 0);
      chk(acc_r, {16'h5A5A, t[i][31:16]}, "sub adjust acc");
      chk(flg_r & 32'h11, t[i][7:0], "sub adjust flags");
    end
  endtask
  task automatic t_add();
    logic [7:0] ops [18] = '{8'h04, 8'h05, 8'h80, 8'h81, 8'h83, 8'h00, 8'h01, 8'h02, 8'h03,
                             8'h14, 8'h15, 8'h80, 8'h81, 8'h83, 8'h10, 8'h11, 8'h12, 8'h13};
    logic [32:0] r;
    logic [31:0] a, b, m, f;
    int w;
    logic c;
    foreach (ops[i]) begin
      a = 32'h7FFFFFF0;
      w = ops[i][0] ? (i[0] ? 16 : 32) : 8;
      m = w == 8 ? 32'hFF : (w == 16 ? 32'hFFFF : 32'hFFFFFFFF);
      b = (ops[i][7] || ops[i][2]) ? 32'h00007F90 : 32'h80000010;
      if (ops[i] == `OP_GRP_SEXT) b = 32'hFFFFFF90;
      c = i >= 9;
      r = (a & m) + (b & m) + c;
      f = `RST_FLAGS;
      f[`FLG_CARRY] = r[w];
      f[`FLG_ZERO] = (r[31:0] & m) == 0;
      f[`FLG_SIGN] = r[w-1];
      f[`FLG_AUX] = a[4] ^ b[4] ^ r[4];
      f[`FLG_PARITY] = ~^r[7:0];
      f[`FLG_OVFL] = (a[w-1] == b[w-1]) && (r[w-1] != a[w-1]);
      run(ops[i], {2'b11, c ? `GRP_ADC : `GRP_ADD, 3'h0}, w == 16 ? 2'h1 : 2'h0, a, 32'h80000010,
          32'h00007F90, a, 32'h3, 0);
      if (ops[i][2]) chk(acc_r, (a & ~m) | (r[31:0] & m), "add acc");
      else chk(res_r & m, r[31:0] & m, "add result");
      chk(flg_r, f, "add flags");
    end
  endtask
  // Entry: error code valid, fault kind, environment word
  task automatic t_fault();
    logic [15:0] t [11] = '{16'h9061, 16'h1120, 16'h90A1, 16'hA222, 16'h2220, 16'hB421, 16'h0420,
                            16'hC83D, 16'h0831, 16'hC832, 16'h9461};
    wr(`REG_XLAT_CODE, 32'h000000A5);
    foreach (t[i]) begin
      run(8'h01, 8'h00, 2'h0, 32'h7FFFFFF0, 32'h80000010, 0, 32'h11112222, 32'h8D7, t[i][11:0]);
      chk(sts_r[6:4], t[i][14:12], "fault kind");
      chk(sts_r[`STS_ERR_VALID], t[i][15], "error code valid");
      chk(sts_r[`STS_DEST_WR], t[i][14:12] == 0, "dest write");
      if (t[i][14:12] != 0) begin
        chk(flg_r, 32'h8D7, "flags kept");
        chk(acc_r, 32'h11112222, "acc kept");
      end
      if (t[i][14:12] == `FK_XLAT) begin
        rd(`REG_FAULT_CODE);
        chk(rd_d, 32'h000000A5, "fault code");
      end
    end
    // Group reg field 4 is refused, divisor zero faults; neither touches state
    run(`OP_GRP_BYTE, 8'hE0, 2'h0, 0, 0, 0, 32'h11112222, 32'h8D7, 0);
    chk(sts_r[`STS_ILLEGAL], 1, "illegal group");
    chk(acc_r, 32'h11112222, "illegal acc kept");
    run(`OP_MULT_ADJUST, 8'h00, 2'h0, 0, 0, 0, 32'h11112222, 32'h8D7, 0);
    chk(sts_r[6:4], `FK_DIVZ, "divide by zero");
    chk(acc_r, 32'h11112222, "divide acc kept");
    chk(flg_r, 32'h8D7, "divide flags kept");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n_i = 1'b0;
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_mult();
    t_sub();
    t_add();
    t_fault();
    give_verdict();
  end
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    failures++;
    give_verdict();
  end
endmodule // bcd_add_unit_tb_top
`default_nettype wire
